// ==== verilog/rtacr_regs.sv ====
// radio trim, pad, supply monitor, test tone, preamble/delimiter, freq corr
//
// Contract
// RULE_01: host sets trim four to 30 for GFSK/FSK, leaves 2 for 802.15.4.
// RULE_02: host clears bandwidth select and second-order enable for GFSK/FSK.
// RULE_03: host writes reserved fields with their defaults on every write.
// RULE_04: pad edge-rate codes: 0 very slow, 1 slow, 2 very fast, 3 fast.
// RULE_05: pad drive codes: 0 4 mA, 1 8 mA, 2 above 8 mA, 3 reserved.
// RULE_06: low-supply event when battery below 1.7 V plus 62 mV per code.
// RULE_07: zero-only bit in bitstream mode sends constant zero.
// RULE_08: one-only bit in bitstream mode sends constant one.
// RULE_09: carrier bit sends unmodulated tone at channel frequency.
// RULE_10: preamble valid once counted bytes reach seven-bit count, reset 5.
// RULE_11: frame delimiter from two four-bit symbols, resets 7 and 10.
// RULE_12: mode 00 holds, 10 runs free, 11 locks on preamble, 01 reserved.
// RULE_13: host sets correction polarity bit to one.
// RULE_14: proportional gain used in GFSK, ignored in 802.15.4.
// RULE_15: integral gain used in GFSK, ignored in 802.15.4.
// RULE_16: correction limited to plus or minus range value in kHz.
// RULE_17: measured frequency error read back at 1 kHz per bit.
// RULE_18: low-supply event reaches interrupt only when enabled.
// RULE_19: error readback updated continuously while the loop is active.
module rtacr_regs (
    input  wire logic               clk,
    input  wire logic               arst_n,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    input  wire logic [3:0]         pstrb,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    output logic                    irq,
    input  wire logic               gfsk_mode,
    input  wire logic               battery_supply_low,
    output logic      [4:0]         trip_code,
    output logic      [4:0]         loop_bandwidth_trim_four,
    output logic      [4:0]         loop_bandwidth_choice,
    output logic                    loop_second_order_en,
    output logic      [1:0]         pad_edge_rank,
    output logic      [1:0]         pad_drive_code,
    input  wire logic               serial_bitstream_mode,
    input  wire logic               tx_bit_in,
    output logic                    tx_data_out,
    output logic                    tx_carrier_only,
    input  wire logic               rx_pre_byte,
    input  wire logic               rx_pre_break,
    input  wire logic               rx_sym_valid,
    input  wire logic [3:0]         rx_sym,
    output logic                    preamble_valid,
    output logic                    delim_found,
    output logic      [7:0]         delim_symbols,
    input  wire logic               fc_err_valid,
    input  wire logic signed [7:0]  fc_err_in,
    output logic signed [8:0]       fc_corr
);
    // =========================================================
    // state
    typedef struct packed {
        logic [7:0]                 bw4;
        logic [7:0]                 bws;
        logic [7:0]                 cfg13;
        logic [7:0]                 pad;
        logic [7:0]                 supply;
        logic [7:0]                 tone;
        logic [7:0]                 preq;
        logic [7:0]                 delim;
        logic [7:0]                 fcfg;
        logic [7:0]                 gains;
        logic [7:0]                 limit;
        logic [7:0]                 fread;
        logic [rtacr_pkg::NUM_EV-1:0] ist;
        logic [rtacr_pkg::NUM_EV-1:0] ien;
        logic                       irq;
        logic                       pready;
        logic                       pslverr;
        logic [31:0]                prdata;
        logic                       b_s1;
        logic                       b_s2;
        logic                       b_prev;
        logic [6:0]                 pcnt;
        rtacr_pkg::rtacr_state_t    st;
        logic                       pre_valid;
        logic                       dfound;
        logic                       locked;
        logic signed [13:0]         integ;
        logic signed [8:0]          corr;
        logic                       tx_data;
        logic                       carrier;
        logic [1:0]                 erank;
        logic [1:0]                 drv;
    } rtacr_s_t;

    rtacr_s_t s;
    rtacr_s_t next_s;

    // =========================================================
    // next-state logic
    always_comb begin
        logic                       acc;
        logic                       hit;
        logic [9:0]                 idx;
        logic [7:0]                 rd;
        logic [rtacr_pkg::NUM_EV-1:0] ev;
        logic [rtacr_pkg::NUM_EV-1:0] clr;
        logic                       active;
        logic [3:0]                 kp;
        logic [3:0]                 ki;
        logic signed [8:0]          e9;
        logic signed [13:0]         lim;
        logic signed [13:0]         ip;
        logic signed [14:0]         sum;
        logic signed [11:0]         raw;
        logic signed [11:0]         rl;
        acc = psel & penable;
        hit = 1'b0;
        idx = paddr[11:2];
        rd = 8'h00;
        ev = '0;
        clr = '0;
        next_s = s;
        next_s.dfound = 1'b0;
        active = 1'b0;
        kp = 4'h0;
        ki = 4'h0;
        e9 = '0;
        lim = '0;
        ip = '0;
        sum = '0;
        raw = '0;
        rl = '0;

        // apb: one wait state, write lands on the edge that sees pready
        case (idx)
            rtacr_pkg::IDX_BW_TRIM4: begin hit = 1'b1; rd = s.bw4; end
            rtacr_pkg::IDX_BW_SEL:   begin hit = 1'b1; rd = s.bws; end
            rtacr_pkg::IDX_CFG13:    begin hit = 1'b1; rd = s.cfg13; end
            rtacr_pkg::IDX_PAD:      begin hit = 1'b1; rd = s.pad; end
            rtacr_pkg::IDX_SUPPLY:   begin hit = 1'b1; rd = s.supply; end
            rtacr_pkg::IDX_TONE:     begin hit = 1'b1; rd = s.tone; end
            rtacr_pkg::IDX_PRE_QUAL: begin hit = 1'b1; rd = s.preq; end
            rtacr_pkg::IDX_DELIM:    begin hit = 1'b1; rd = s.delim; end
            rtacr_pkg::IDX_FC_CFG:   begin hit = 1'b1; rd = s.fcfg; end
            rtacr_pkg::IDX_FC_GAINS: begin hit = 1'b1; rd = s.gains; end
            rtacr_pkg::IDX_FC_LIMIT: begin hit = 1'b1; rd = s.limit; end
            rtacr_pkg::IDX_FC_READ:  begin hit = 1'b1; rd = s.fread; end
            rtacr_pkg::IDX_IRQ_STAT: begin hit = 1'b1; rd = {5'h00, s.ist}; end
            rtacr_pkg::IDX_IRQ_EN:   begin hit = 1'b1; rd = {5'h00, s.ien}; end
            rtacr_pkg::IDX_IRQ_CLR:  begin hit = 1'b1; rd = 8'h00; end
            default:                 begin hit = 1'b0; rd = 8'h00; end
        endcase
        if (paddr[1:0] != 2'h0) begin
            hit = 1'b0;
        end
        if (acc && s.pready) begin
            next_s.pready = 1'b0;
            next_s.pslverr = 1'b0;
            next_s.prdata = 32'h0000_0000;
            // all eight bits of config registers stored, reserved fields kept as written [RULE_03]
            if (pwrite && pstrb[0] && hit) begin
                case (idx)
                    rtacr_pkg::IDX_BW_TRIM4: next_s.bw4 = pwdata[7:0];
                    rtacr_pkg::IDX_BW_SEL:   next_s.bws = pwdata[7:0];
                    rtacr_pkg::IDX_CFG13:    next_s.cfg13 = pwdata[7:0];
                    rtacr_pkg::IDX_PAD:      next_s.pad = pwdata[7:0];
                    rtacr_pkg::IDX_SUPPLY:   next_s.supply = pwdata[7:0];
                    rtacr_pkg::IDX_TONE:     next_s.tone = pwdata[7:0];
                    rtacr_pkg::IDX_PRE_QUAL: next_s.preq = pwdata[7:0];
                    rtacr_pkg::IDX_DELIM:    next_s.delim = pwdata[7:0];
                    rtacr_pkg::IDX_FC_CFG:   next_s.fcfg = pwdata[7:0];
                    rtacr_pkg::IDX_FC_GAINS: next_s.gains = pwdata[7:0];
                    rtacr_pkg::IDX_FC_LIMIT: next_s.limit = pwdata[7:0];
                    rtacr_pkg::IDX_FC_READ:  next_s.fread = pwdata[7:0];
                    rtacr_pkg::IDX_IRQ_EN:
                        next_s.ien = pwdata[rtacr_pkg::NUM_EV-1:0];
                    rtacr_pkg::IDX_IRQ_CLR:
                        clr = pwdata[rtacr_pkg::NUM_EV-1:0];
                    default: next_s.pslverr = 1'b0;
                endcase
            end
        end else if (acc) begin
            next_s.pready = 1'b1;
            next_s.pslverr = ~hit;
            next_s.prdata = pwrite ? 32'h0000_0000 : {24'h00_0000, rd};
        end else begin
            next_s.pready = 1'b0;
            next_s.pslverr = 1'b0;
        end

        // =====================================================
        // battery comparator level, synchronised
        next_s.b_s1 = battery_supply_low;
        next_s.b_s2 = s.b_s1;
        next_s.b_prev = s.b_s2;
        ev[rtacr_pkg::EV_LOW_SUPPLY] = s.b_s2 & ~s.b_prev; // [RULE_06]

        // =====================================================
        // pad decode: rank 0 slowest .. 3 fastest
        case (next_s.pad[3:2]) // [RULE_04]
            2'h0:    next_s.erank = 2'h0;
            2'h1:    next_s.erank = 2'h1;
            2'h2:    next_s.erank = 2'h3;
            default: next_s.erank = 2'h2;
        endcase
        // reserved drive code falls back to the weakest setting
        next_s.drv = (next_s.pad[1:0] == 2'h3) ? 2'h0
                                               : next_s.pad[1:0]; // [RULE_05]

        // =====================================================
        // test tones; zero-only wins if both tone bits are set
        if (serial_bitstream_mode &&
            s.tone[rtacr_pkg::TONE_ZERO_BIT]) begin
            next_s.tx_data = 1'b0; // [RULE_07]
        end else if (serial_bitstream_mode &&
                     s.tone[rtacr_pkg::TONE_ONE_BIT]) begin
            next_s.tx_data = 1'b1; // [RULE_08]
        end else begin
            next_s.tx_data = tx_bit_in;
        end
        next_s.carrier = s.tone[rtacr_pkg::TONE_CARRIER_BIT]; // [RULE_09]

        // =====================================================
        // preamble qualification and delimiter hunt
        if (rx_pre_break) begin
            next_s.pcnt = 7'h00;
            next_s.st = rtacr_pkg::RTACR_HUNT;
        end else begin
            if (rx_pre_byte && s.pcnt != 7'h7f) begin
                next_s.pcnt = s.pcnt + 7'h01; // [RULE_10]
            end
            case (s.st)
                rtacr_pkg::RTACR_HUNT: begin
                    if (s.pre_valid) begin
                        next_s.st = rtacr_pkg::RTACR_WAIT1;
                    end
                end
                rtacr_pkg::RTACR_WAIT1: begin
                    if (rx_sym_valid && rx_sym == s.delim[3:0]) begin
                        next_s.st = rtacr_pkg::RTACR_WAIT2; // [RULE_11]
                    end
                end
                rtacr_pkg::RTACR_WAIT2: begin
                    if (rx_sym_valid && rx_sym == s.delim[7:4]) begin
                        next_s.dfound = 1'b1; // [RULE_11]
                        next_s.pcnt = 7'h00;
                        next_s.st = rtacr_pkg::RTACR_HUNT;
                    end else if (rx_sym_valid &&
                                 rx_sym != s.delim[3:0]) begin
                        next_s.st = rtacr_pkg::RTACR_WAIT1;
                    end
                end
                default: next_s.st = rtacr_pkg::RTACR_HUNT;
            endcase
        end
        next_s.pre_valid = (next_s.pcnt >= s.preq[6:0]); // [RULE_10]
        ev[rtacr_pkg::EV_PRE_VALID] = next_s.pre_valid & ~s.pre_valid;
        ev[rtacr_pkg::EV_DELIM] = next_s.dfound;

        // =====================================================
        // frequency-correction pi loop
        if (s.fcfg[1:0] != rtacr_pkg::FC_LOCK_PRE || rx_pre_break) begin
            next_s.locked = 1'b0;
        end else if (s.pre_valid) begin
            next_s.locked = 1'b1; // [RULE_12]
        end
        // reserved mode 01 behaves as hold
        active = (s.fcfg[1:0] == rtacr_pkg::FC_FREE) ||
                 (s.fcfg[1:0] == rtacr_pkg::FC_LOCK_PRE &&
                  !s.locked); // [RULE_12]
        kp = gfsk_mode ? s.gains[7:4]
                       : rtacr_pkg::FIX_PROP_GAIN; // [RULE_14]
        ki = gfsk_mode ? s.gains[3:0]
                       : rtacr_pkg::FIX_INTEG_GAIN; // [RULE_15]
        // nine bits so that negating -128 cannot overflow
        e9 = s.fcfg[rtacr_pkg::FC_POL_BIT] ? -9'(fc_err_in)
                                           : 9'(fc_err_in);
        lim = 14'({s.limit, 3'b000});
        ip = s.integ;
        if (active && fc_err_valid) begin
            ip = s.integ + 14'(e9 * $signed({1'b0, ki})); // [RULE_15]
            // clamping the integrator stops wind-up past the range
            if (ip > lim) begin
                ip = lim;
            end else if (ip < -lim) begin
                ip = -lim;
            end
            next_s.integ = ip;
            sum = 15'(ip) + 15'(e9 * $signed({1'b0, kp})); // [RULE_14]
            raw = 12'(sum >>> rtacr_pkg::PI_FRAC);
        end else begin
            raw = 12'(s.corr);
        end
        // clamp also applies while holding, so a lowered range bites
        rl = 12'({s.limit});
        if (raw > rl) begin
            raw = rl;
        end else if (raw < -rl) begin
            raw = -rl;
        end
        next_s.corr = 9'(raw); // [RULE_16]
        if (active && fc_err_valid) begin
            next_s.fread = fc_err_in; // [RULE_17] [RULE_19]
        end

        // =====================================================
        // interrupts: set wins over clear
        next_s.ist = (s.ist & ~clr) | ev;
        next_s.irq = |(next_s.ist & next_s.ien); // [RULE_18]
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
            s.bw4 <= rtacr_pkg::RST_BW_TRIM4;
            s.bws <= rtacr_pkg::RST_BW_SEL;
            s.cfg13 <= rtacr_pkg::RST_CFG13;
            s.pad <= rtacr_pkg::RST_PAD;
            s.supply <= rtacr_pkg::RST_SUPPLY;
            s.tone <= rtacr_pkg::RST_TONE;
            s.preq <= rtacr_pkg::RST_PRE_QUAL;
            s.delim <= rtacr_pkg::RST_DELIM;
            s.fcfg <= rtacr_pkg::RST_FC_CFG;
            s.gains <= rtacr_pkg::RST_FC_GAINS;
            s.limit <= rtacr_pkg::RST_FC_LIMIT;
            s.fread <= rtacr_pkg::RST_FC_READ;
            s.st <= rtacr_pkg::RTACR_HUNT;
        end else begin
            s <= next_s;
        end
    end

    // =========================================================
    // outputs
    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign irq = s.irq;
    assign trip_code = s.supply[4:0]; // [RULE_06]
    assign loop_bandwidth_trim_four = s.bw4[4:0];
    assign loop_bandwidth_choice = s.bws[4:0];
    assign loop_second_order_en = s.cfg13[rtacr_pkg::SECOND_ORDER_BIT];
    assign pad_edge_rank = s.erank;
    assign pad_drive_code = s.drv;
    assign tx_data_out = s.tx_data;
    assign tx_carrier_only = s.carrier;
    assign preamble_valid = s.pre_valid;
    assign delim_found = s.dfound;
    assign delim_symbols = s.delim; // [RULE_11]
    assign fc_corr = s.corr;

    // =========================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_tone_zero: assert property ( // [RULE_07]
        serial_bitstream_mode && s.tone[rtacr_pkg::TONE_ZERO_BIT]
        |=> !tx_data_out)
        else $error("zero-only tone not constant zero");
    a_tone_one: assert property ( // [RULE_08]
        serial_bitstream_mode && !s.tone[rtacr_pkg::TONE_ZERO_BIT]
        && s.tone[rtacr_pkg::TONE_ONE_BIT] |=> tx_data_out)
        else $error("one-only tone not constant one");
    a_carrier_tone: assert property ( // [RULE_09]
        ##1 tx_carrier_only == $past(s.tone[rtacr_pkg::TONE_CARRIER_BIT]))
        else $error("carrier output does not follow its bit");
    a_pre_count: assert property ( // [RULE_10]
        preamble_valid == (s.pcnt >= $past(s.preq[6:0])))
        else $error("preamble valid disagrees with count");
    a_delim_order: assert property ( // [RULE_11]
        delim_found |-> $past(s.st == rtacr_pkg::RTACR_WAIT2)
        && $past(rx_sym) == $past(s.delim[7:4]))
        else $error("delimiter found without second symbol");
    a_corr_hold: assert property ( // [RULE_12]
        s.fcfg[1:0] == rtacr_pkg::FC_HOLD && $stable(s.limit)
        |=> $stable(fc_corr))
        else $error("correction moved in hold mode");
    a_corr_limit: assert property ( // [RULE_16]
        ##1 (fc_corr <= $signed({1'b0, $past(s.limit)}) &&
             fc_corr >= -$signed({1'b0, $past(s.limit)})))
        else $error("correction outside pull-in range");
    a_read_track: assert property ( // [RULE_19]
        s.fcfg[1:0] == rtacr_pkg::FC_FREE && fc_err_valid
        |=> s.fread == $past(fc_err_in))
        else $error("error readback not updated");
    a_supply_flag: assert property ( // [RULE_06]
        s.b_s2 && !s.b_prev |=> s.ist[rtacr_pkg::EV_LOW_SUPPLY])
        else $error("low-supply event not recorded");
    a_irq_gate: assert property ( // [RULE_18]
        irq == |(s.ist & s.ien))
        else $error("interrupt level disagrees with enables");
    a_edge_map: assert property ( // [RULE_04]
        s.pad[3:2] == 2'h2 && $stable(s.pad) |-> pad_edge_rank == 2'h3)
        else $error("very fast edge code mis-decoded");
endmodule

// ==== verilog/rtacr_pkg.sv ====
// shared constants of the radio trim and frequency-correction register bank
package rtacr_pkg;
    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_BW_TRIM4  = 10'h3d6;
    localparam logic [9:0] IDX_BW_SEL    = 10'h3d7;
    localparam logic [9:0] IDX_CFG13     = 10'h3e0;
    localparam logic [9:0] IDX_PAD       = 10'h3e3;
    localparam logic [9:0] IDX_SUPPLY    = 10'h3e6;
    localparam logic [9:0] IDX_TONE      = 10'h3f0;
    localparam logic [9:0] IDX_PRE_QUAL  = 10'h3f3;
    localparam logic [9:0] IDX_DELIM     = 10'h3f4;
    localparam logic [9:0] IDX_FC_CFG    = 10'h3f7;
    localparam logic [9:0] IDX_FC_GAINS  = 10'h3f8;
    localparam logic [9:0] IDX_FC_LIMIT  = 10'h3f9;
    localparam logic [9:0] IDX_FC_READ   = 10'h3fa;
    localparam logic [9:0] IDX_IRQ_STAT  = 10'h3fc;
    localparam logic [9:0] IDX_IRQ_EN    = 10'h3fd;
    localparam logic [9:0] IDX_IRQ_CLR   = 10'h3fe;
    // values after reset
    localparam logic [7:0] RST_BW_TRIM4  = 8'h02;
    localparam logic [7:0] RST_BW_SEL    = 8'h00;
    localparam logic [7:0] RST_CFG13     = 8'hf2;
    localparam logic [7:0] RST_PAD       = 8'h00;
    localparam logic [7:0] RST_SUPPLY    = 8'h00;
    localparam logic [7:0] RST_TONE      = 8'h20;
    localparam logic [7:0] RST_PRE_QUAL  = 8'h05;
    localparam logic [7:0] RST_DELIM     = 8'ha7;
    localparam logic [7:0] RST_FC_CFG    = 8'h00;
    localparam logic [7:0] RST_FC_GAINS  = 8'h00;
    localparam logic [7:0] RST_FC_LIMIT  = 8'h00;
    localparam logic [7:0] RST_FC_READ   = 8'h00;
    // field positions
    localparam int SECOND_ORDER_BIT = 1;
    localparam int TONE_ZERO_BIT    = 3;
    localparam int TONE_ONE_BIT     = 2;
    localparam int TONE_CARRIER_BIT = 1;
    localparam int FC_POL_BIT       = 2;
    // interrupt event bits
    localparam int EV_LOW_SUPPLY = 0;
    localparam int EV_PRE_VALID  = 1;
    localparam int EV_DELIM      = 2;
    localparam int NUM_EV        = 3;
    // frequency-correction modes
    localparam logic [1:0] FC_HOLD     = 2'h0;
    localparam logic [1:0] FC_FREE     = 2'h2;
    localparam logic [1:0] FC_LOCK_PRE = 2'h3;
    // fixed gains used in 802.15.4 operation, integrator fraction bits
    localparam logic [3:0] FIX_PROP_GAIN  = 4'h0;
    localparam logic [3:0] FIX_INTEG_GAIN = 4'h1;
    localparam int         PI_FRAC        = 3;
    typedef enum logic [2:0] {
        RTACR_HUNT  = 3'b001,
        RTACR_WAIT1 = 3'b010,
        RTACR_WAIT2 = 3'b100
    } rtacr_state_t;
endpackage

// ==== test/test_rtacr_regs.sv ====
// self-checking bench of the radio trim and frequency-correction bank
module test_rtacr_regs;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [9:0] idx;
        logic [7:0] rst;
        logic [7:0] wv;
    } rtacr_row_t;
    logic              clk, arst_n, psel, penable, pwrite, pready, pslverr;
    logic              irq, gfsk, batt, sbm, txb, txd, txc, pbyte, pbrk;
    logic              svld, pvalid, dfound, fvld, so_en;
    logic [11:0]       paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic [3:0]        pstrb, sym;
    logic [4:0]        trip, bw4, bwc;
    logic [1:0]        edge_r, drv;
    logic [7:0]        dsym;
    logic signed [7:0] ferr;
    logic signed [8:0] corr;
    logic              err, seen;
    int                num_errors = 0;
    int                checks = 0;
    rtacr_row_t        rows [12];
    rtacr_regs rtacr_regs_inst (.clk(clk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .gfsk_mode(gfsk), .battery_supply_low(batt),
        .trip_code(trip), .loop_bandwidth_trim_four(bw4),
        .loop_bandwidth_choice(bwc), .loop_second_order_en(so_en),
        .pad_edge_rank(edge_r), .pad_drive_code(drv),
        .serial_bitstream_mode(sbm), .tx_bit_in(txb), .tx_data_out(txd),
        .tx_carrier_only(txc), .rx_pre_byte(pbyte), .rx_pre_break(pbrk),
        .rx_sym_valid(svld), .rx_sym(sym), .preamble_valid(pvalid),
        .delim_found(dfound), .delim_symbols(dsym), .fc_err_valid(fvld),
        .fc_err_in(ferr), .fc_corr(corr));
    // ====================================================================
    // helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // waits for pready without assuming the slave's latency
    task automatic apb(input logic w, input logic [9:0] idx,
                       input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w;
        paddr <= {idx, 2'b00}; pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        forever begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic rdc(input logic [9:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(rd, {24'h0, exp});
    endtask
    task automatic pulse_fc(input logic signed [7:0] e);
        @(posedge clk); fvld <= 1'b1; ferr <= e;
        @(posedge clk); fvld <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic tone(input logic [7:0] t, input logic m, input logic b,
                        input logic ed, input logic ec);
        @(posedge clk); sbm <= m; txb <= b;
        apb(1'b1, rtacr_pkg::IDX_TONE, t);
        repeat (3) @(posedge clk);
        chk({30'h0, txd, txc}, {30'h0, ed, ec});
    endtask
    task automatic test_done;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #100000;
        num_errors++;
        test_done();
    end
    // ====================================================================
    // main sequence
    initial begin
        {psel, penable, pwrite, gfsk, batt, sbm, txb, pbyte} = '0;
        {pbrk, svld, fvld} = '0;
        paddr = '0; pwdata = '0; pstrb = 4'hf; sym = '0; ferr = '0;
        arst_n = 1'b0;
        rows = '{
            '{rtacr_pkg::IDX_BW_TRIM4, 8'h02, 8'h1e},
            '{rtacr_pkg::IDX_BW_SEL, 8'h00, 8'h00},
            '{rtacr_pkg::IDX_CFG13, 8'hf2, 8'hf0},
            '{rtacr_pkg::IDX_PAD, 8'h00, 8'h0e},
            '{rtacr_pkg::IDX_SUPPLY, 8'h00, 8'h0b},
            '{rtacr_pkg::IDX_TONE, 8'h20, 8'h20},
            '{rtacr_pkg::IDX_PRE_QUAL, 8'h05, 8'h03},
            '{rtacr_pkg::IDX_DELIM, 8'ha7, 8'ha7},
            '{rtacr_pkg::IDX_FC_CFG, 8'h00, 8'h06},
            '{rtacr_pkg::IDX_FC_GAINS, 8'h00, 8'h99},
            '{rtacr_pkg::IDX_FC_LIMIT, 8'h00, 8'h64},
            '{rtacr_pkg::IDX_FC_READ, 8'h00, 8'h5a}};
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk); #1;
        chk({26'h0, bw4, so_en}, {26'h0, 5'd2, 1'b1});
        chk({24'h0, dsym}, 32'h0000_00a7);
        foreach (rows[i]) begin
            rdc(rows[i].idx, rows[i].rst);
            apb(1'b1, rows[i].idx, rows[i].wv);
            rdc(rows[i].idx, rows[i].wv);
        end
        gfsk <= 1'b1;
        @(posedge clk); #1;
        chk({21'h0, bw4, bwc, so_en}, {21'h0, 5'd30, 5'd0, 1'b0});
        chk({28'h0, edge_r, drv}, 32'h0000_000a);
        chk({27'h0, trip}, 32'd11);
        apb(1'b0, 10'h000, 8'h00);
        chk({rd[30:0], err}, 32'h0000_0001);
        tone(8'h28, 1'b1, 1'b1, 1'b0, 1'b0);
        tone(8'h24, 1'b1, 1'b0, 1'b1, 1'b0);
        tone(8'h22, 1'b1, 1'b1, 1'b1, 1'b1);
        tone(8'h28, 1'b0, 1'b1, 1'b1, 1'b0);
        // preamble qualify count is 3: two bytes must not suffice
        repeat (2) begin
            @(posedge clk); pbyte <= 1'b1;
            @(posedge clk); pbyte <= 1'b0;
        end
        repeat (2) @(posedge clk); #1;
        chk({31'h0, pvalid}, 32'h0);
        @(posedge clk); pbyte <= 1'b1;
        @(posedge clk); pbyte <= 1'b0;
        repeat (2) @(posedge clk); #1;
        chk({31'h0, pvalid}, 32'h1);
        @(posedge clk); svld <= 1'b1; sym <= 4'h7;
        @(posedge clk); sym <= 4'ha;
        @(posedge clk); svld <= 1'b0;
        seen = 1'b0;
        repeat (4) begin
            #1;
            if (dfound === 1'b1) seen = 1'b1;
            @(posedge clk);
        end
        chk({31'h0, seen}, 32'h1);
        rdc(rtacr_pkg::IDX_IRQ_STAT, 8'h06);
        apb(1'b1, rtacr_pkg::IDX_IRQ_CLR, 8'h07);
        pulse_fc(-8'sd16);
        chk({23'h0, corr}, 32'd36);
        rdc(rtacr_pkg::IDX_FC_READ, 8'hf0);
        apb(1'b1, rtacr_pkg::IDX_FC_LIMIT, 8'h0a);
        pulse_fc(-8'sd16);
        chk({23'h0, corr}, 32'd10);
        apb(1'b1, rtacr_pkg::IDX_FC_CFG, 8'h04);
        pulse_fc(8'sd16);
        chk({23'h0, corr}, 32'd10);
        rdc(rtacr_pkg::IDX_FC_READ, 8'hf0);
        // supply alert held back until enabled, then cleared
        @(posedge clk); batt <= 1'b1;
        repeat (6) @(posedge clk); #1;
        chk({31'h0, irq}, 32'h0);
        rdc(rtacr_pkg::IDX_IRQ_STAT, 8'h01);
        apb(1'b1, rtacr_pkg::IDX_IRQ_EN, 8'h01);
        repeat (2) @(posedge clk); #1;
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, rtacr_pkg::IDX_IRQ_CLR, 8'h01);
        repeat (2) @(posedge clk); #1;
        chk({31'h0, irq}, 32'h0);
        // lock on preamble: runs until the preamble qualifies, then freezes
        apb(1'b1, rtacr_pkg::IDX_FC_CFG, 8'h07);
        pulse_fc(8'sd16);
        chk({23'h0, corr}, 32'h0000_01f6);
        apb(1'b1, rtacr_pkg::IDX_PRE_QUAL, 8'h00);
        repeat (2) @(posedge clk);
        pulse_fc(-8'sd16);
        chk({23'h0, corr}, 32'h0000_01f6);
        // reset in mid-run brings every register back to its default
        @(posedge clk); arst_n <= 1'b0;
        @(posedge clk); arst_n <= 1'b1;
        @(posedge clk); #1;
        chk({24'h0, dsym}, 32'h0000_00a7);
        chk({23'h0, corr}, 32'h0);
        rdc(rtacr_pkg::IDX_PRE_QUAL, 8'h05);
        test_done();
    end
endmodule
